// [pkg/eqc_pkg.sv]
// shared constants, types and decode helpers of the equalizer configuration block
package eqc_pkg;
    // register offsets
    localparam logic [7:0] ADDR_MUTE = 8'h03;
    localparam logic [7:0] ADDR_CLI = 8'h25;
    localparam logic [7:0] ADDR_AMP0 = 8'h30;
    localparam logic [7:0] ADDR_DEM0 = 8'h31;
    localparam logic [7:0] ADDR_AMP1 = 8'h32;
    localparam logic [7:0] ADDR_DEM1 = 8'h33;
    localparam logic [7:0] ADDR_PATH = 8'h10;
    // writable bits of each register, the rest reads as zero
    localparam logic [7:0] MASK_MUTE = 8'h3F;
    localparam logic [7:0] MASK_AMP = 8'h27;
    localparam logic [7:0] MASK_DEM = 8'h47;
    localparam logic [7:0] MASK_PATH = 8'h1F;
    // field positions
    localparam int AMP_OVR_BIT = 5;
    localparam int DEM_OVR_BIT = 6;
    localparam int PATH_ROUTE_OVR = 0;
    localparam int PATH_ROUTE_BOTH = 1;
    localparam int PATH_FUNC_OVR = 2;
    localparam int PATH_FUNC_BYP = 3;
    localparam int PATH_SPLIT = 4;
    // reset values
    localparam logic [7:0] RST_MUTE = 8'h3F;
    localparam logic [7:0] RST_DRV = 8'h00;
    localparam logic [7:0] RST_PATH = 8'h00;
    // counts and limits
    localparam logic [5:0] CLI_MAX = 6'h37;
    localparam logic [6:0] SMB_ADDR_BASE = 7'h1D;
    localparam logic [4:0] SPI_FRAME_BITS = 5'h11;
    localparam logic [1:0] BOOT_CAPTURE = 2'h2;
    localparam logic [1:0] BOOT_DONE = 2'h3;
    localparam logic [3:0] SMB_ACK_BIT = 4'h8;
    localparam logic [3:0] SMB_END_BIT = 4'h9;

    typedef enum logic [1:0] {
        LVL_L = 2'h0,
        LVL_R = 2'h1,
        LVL_F = 2'h2,
        LVL_H = 2'h3
    } eqc_lvl_t;

    typedef enum logic [2:0] {
        SMB_IDLE = 3'h0,
        SMB_ADDR = 3'h1,
        SMB_REG = 3'h3,
        SMB_DATA = 3'h2,
        SMB_READ = 3'h6
    } eqc_smb_t;

    typedef struct packed {
        logic [2:0] amp;
        logic [2:0] deemphasis_level;
    } eqc_drv_t;

    // comparator thermometer at 0.2, 0.5 and 0.8 of supply to level
    function automatic eqc_lvl_t strap_lvl(input logic [2:0] t);
        case (t)
            3'h7: strap_lvl = LVL_H;
            3'h3: strap_lvl = LVL_F;
            3'h1: strap_lvl = LVL_R;
            default: strap_lvl = LVL_L;
        endcase
    endfunction

    // strap level to amplitude and de-emphasis code
    function automatic logic [2:0] lvl_code(input eqc_lvl_t l);
        case (l)
            LVL_H: lvl_code = 3'h0;
            LVL_F: lvl_code = 3'h2;
            LVL_R: lvl_code = 3'h3;
            default: lvl_code = 3'h5;
        endcase
    endfunction
endpackage

// [core/eqc_top.sv]
// strap decode, override registers, spi and smbus register ports of the equalizer
//Function
//- Routing strap H drives both outputs, F drives only output zero, R and L are reserved.
//- Routing and function strap values are defaults that set override bits replace.
//- Function strap H bypasses the equalizer, F sends equalized data, overridable by register.
//- The drive level strap gives codes 0, 2, 3 and 5 for H, F, R and L to both outputs.
//- A per-output override bit replaces the strap code with that output's own field.
//- Amplitude and de-emphasis fields take any code up to 7.
//- The cable length estimate reads as six bits from 0 to 55.
//- Outputs mute when the cable length exceeds the six-bit mute threshold.
//- Splitter mode is enabled only through the serial register port.
//- The interface strap caught at power-up selects smbus, spi, or power save with spi.
//- Carrier indicator goes low after adaptation above threshold, high with eq off below.
//- Each four-level strap decodes to L, R, F or H from three comparators.
module eqc_top (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // four-level straps as comparator thermometers
    input wire logic [2:0] route_strap_i,
    input wire logic [2:0] func_strap_i,
    input wire logic [2:0] drive_level_strap_i,
    input wire logic [2:0] mode_strap_i,
    input wire logic [2:0] addr0_strap_i,
    input wire logic [2:0] addr1_strap_i,
    // analog status
    input wire logic [5:0] cable_length_indicator_i,
    input wire logic carrier_above_i,
    input wire logic adapt_done_i,
    // spi port
    input wire logic spi_sck_i,
    input wire logic spi_mosi_i,
    input wire logic spi_ss_n_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    // smbus port, open drain
    input wire logic smb_scl_i,
    input wire logic smb_sda_i,
    output logic smb_sda_o,
    output logic smb_sda_oe_o,
    // datapath control
    output logic output_zero_en_o,
    output logic output_one_en_o,
    output logic eq_bypass_o,
    output eqc_pkg::eqc_drv_t output_zero_drv_o,
    output eqc_pkg::eqc_drv_t output_one_drv_o,
    output logic splitter_mode_o,
    output logic mute_o,
    output logic carrier_present_n_o,
    output logic eq_power_down_o,
    output logic power_save_o,
    output logic smbus_mode_o
);
    localparam int SYNC_W = 31;

    logic [SYNC_W-1:0] async_in, sync1_ff, sync2_ff;
    logic [3:0] prev_ff;
    logic [2:0] route_t, func_t, drv_t, mode_t, a0_t, a1_t;
    logic [5:0] cli_s;
    logic car_s, adp_s, sck_s, mosi_s, ss_n_s, scl_s, sda_s;
    eqc_pkg::eqc_lvl_t route_lvl, func_lvl, drv_lvl, mode_ff, nxt_mode;
    logic [1:0] boot_ff, nxt_boot;
    logic [6:0] saddr_ff, nxt_saddr;
    logic spi_en, smb_en, psave;
    logic [7:0] mute_ff, amp0_ff, dem0_ff, amp1_ff, dem1_ff, path_ff;
    logic [7:0] nxt_mute, nxt_amp0, nxt_dem0, nxt_amp1, nxt_dem1, nxt_path;
    logic [16:0] spi_sh_ff, nxt_spi_sh;
    logic [4:0] spi_cnt_ff, nxt_spi_cnt;
    logic miso_ff, nxt_miso, miso_oe_ff, nxt_miso_oe;
    logic spi_wr, smb_wr;
    logic [7:0] spi_wa, spi_wd, smb_wd;
    eqc_pkg::eqc_smb_t smb_st_ff, nxt_smb_st;
    logic [3:0] smb_cnt_ff, nxt_smb_cnt;
    logic [7:0] smb_sh_ff, nxt_smb_sh, smb_ptr_ff, nxt_smb_ptr;
    logic sda_oe_ff, nxt_sda_oe, smb_nack_ff, nxt_smb_nack;
    logic [5:0] cli_rd;
    logic output_zero_ff, output_one_ff, byp_ff, split_ff, mute_o_ff, cdn_ff, eqpd_ff, ps_ff, smbm_ff;
    eqc_pkg::eqc_drv_t drv0_ff, drv1_ff;
    logic nxt_output_zero, nxt_output_one, nxt_byp, nxt_cdn, nxt_eqpd, nxt_mute_o;
    eqc_pkg::eqc_drv_t nxt_drv0, nxt_drv1;

    // every pin input other than clock and reset passes two flops before use
    assign async_in = {route_strap_i, func_strap_i, drive_level_strap_i, mode_strap_i,
                       addr0_strap_i, addr1_strap_i, cable_length_indicator_i, carrier_above_i,
                       adapt_done_i, spi_sck_i, spi_mosi_i, spi_ss_n_i, smb_scl_i, smb_sda_i};
    assign {route_t, func_t, drv_t, mode_t, a0_t, a1_t, cli_s, car_s, adp_s, sck_s, mosi_s,
            ss_n_s, scl_s, sda_s} = sync2_ff;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            prev_ff <= 4'hF;
        end else begin
            sync1_ff <= async_in;
            sync2_ff <= sync1_ff;
            prev_ff <= {sck_s, ss_n_s, scl_s, sda_s};
        end
    end

    // strap decode, continuous for datapath straps
    assign route_lvl = eqc_pkg::strap_lvl(route_t);
    assign func_lvl = eqc_pkg::strap_lvl(func_t);
    assign drv_lvl = eqc_pkg::strap_lvl(drv_t);
    // estimate is clamped so a glitching front end never reads above the range
    assign cli_rd = (cli_s > eqc_pkg::CLI_MAX) ? eqc_pkg::CLI_MAX : cli_s;

    // read mux shared by both serial ports
    function automatic logic [7:0] rd_data(input logic [7:0] a);
        case (a)
            eqc_pkg::ADDR_MUTE: rd_data = mute_ff;
            eqc_pkg::ADDR_CLI: rd_data = {2'h0, cli_rd};
            eqc_pkg::ADDR_AMP0: rd_data = amp0_ff;
            eqc_pkg::ADDR_DEM0: rd_data = dem0_ff;
            eqc_pkg::ADDR_AMP1: rd_data = amp1_ff;
            eqc_pkg::ADDR_DEM1: rd_data = dem1_ff;
            eqc_pkg::ADDR_PATH: rd_data = path_ff;
            default: rd_data = 8'h00;
        endcase
    endfunction

    // mode strap caught once, after the synchroniser has settled past reset
    assign psave = (mode_ff == eqc_pkg::LVL_H);
    assign spi_en = (boot_ff == eqc_pkg::BOOT_DONE) &&
                    (mode_ff == eqc_pkg::LVL_F || psave);
    assign smb_en = (boot_ff == eqc_pkg::BOOT_DONE) && (mode_ff == eqc_pkg::LVL_L);
    always_comb begin
        nxt_boot = (boot_ff == eqc_pkg::BOOT_DONE) ? boot_ff : boot_ff + 2'h1;
        nxt_mode = mode_ff;
        nxt_saddr = saddr_ff;
        if (boot_ff == eqc_pkg::BOOT_CAPTURE) begin
            nxt_mode = eqc_pkg::strap_lvl(mode_t);
            nxt_saddr = eqc_pkg::SMB_ADDR_BASE +
                        7'({eqc_pkg::strap_lvl(a0_t), eqc_pkg::strap_lvl(a1_t)});
        end
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            boot_ff <= 2'h0;
            mode_ff <= eqc_pkg::LVL_R;
            saddr_ff <= 7'h00;
        end else begin
            boot_ff <= nxt_boot;
            mode_ff <= nxt_mode;
            saddr_ff <= nxt_saddr;
        end
    end

    // spi slave: 17-bit frame, previous frame shifts out while the new one shifts in;
    // sck is oversampled, so it must stay below a quarter of the system clock
    always_comb begin
        nxt_spi_sh = spi_sh_ff;
        nxt_spi_cnt = spi_cnt_ff;
        nxt_miso = miso_ff;
        nxt_miso_oe = spi_en && !ss_n_s;
        spi_wr = 1'b0;
        spi_wa = spi_sh_ff[15:8];
        spi_wd = spi_sh_ff[7:0];
        if (spi_en && !ss_n_s) begin
            if (prev_ff[2]) begin
                nxt_spi_cnt = 5'h00;
                nxt_miso = spi_sh_ff[16];
            end else if (sck_s && !prev_ff[3]) begin
                nxt_spi_sh = {spi_sh_ff[15:0], mosi_s};
                nxt_spi_cnt = (spi_cnt_ff == 5'h1F) ? spi_cnt_ff : spi_cnt_ff + 5'h01;
            end else if (!sck_s && prev_ff[3]) begin
                nxt_miso = spi_sh_ff[16];
            end
        end
        // command runs on the rising select edge, only for a whole frame
        if (spi_en && ss_n_s && !prev_ff[2] && spi_cnt_ff == eqc_pkg::SPI_FRAME_BITS) begin
            if (!spi_sh_ff[16]) begin
                spi_wr = 1'b1;
            end else begin
                nxt_spi_sh = {spi_sh_ff[16:8], rd_data(spi_sh_ff[15:8])};
            end
        end
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            spi_sh_ff <= '0;
            spi_cnt_ff <= 5'h00;
            miso_ff <= 1'b0;
            miso_oe_ff <= 1'b0;
        end else begin
            spi_sh_ff <= nxt_spi_sh;
            spi_cnt_ff <= nxt_spi_cnt;
            miso_ff <= nxt_miso;
            miso_oe_ff <= nxt_miso_oe;
        end
    end

    // smbus slave: address, register pointer, then write data or read data
    always_comb begin
        nxt_smb_st = smb_st_ff;
        nxt_smb_cnt = smb_cnt_ff;
        nxt_smb_sh = smb_sh_ff;
        nxt_smb_ptr = smb_ptr_ff;
        nxt_sda_oe = sda_oe_ff;
        nxt_smb_nack = smb_nack_ff;
        smb_wr = 1'b0;
        smb_wd = smb_sh_ff;
        if (!smb_en) begin
            nxt_smb_st = eqc_pkg::SMB_IDLE;
            nxt_sda_oe = 1'b0;
        end else if (scl_s && prev_ff[1] && prev_ff[0] && !sda_s) begin
            nxt_smb_st = eqc_pkg::SMB_ADDR; // start or repeated start
            nxt_smb_cnt = 4'h0;
            nxt_sda_oe = 1'b0;
        end else if (scl_s && prev_ff[1] && !prev_ff[0] && sda_s) begin
            nxt_smb_st = eqc_pkg::SMB_IDLE; // stop
            nxt_sda_oe = 1'b0;
        end else if (smb_st_ff != eqc_pkg::SMB_IDLE && scl_s && !prev_ff[1]) begin
            if (smb_cnt_ff < eqc_pkg::SMB_ACK_BIT) begin
                nxt_smb_sh = {smb_sh_ff[6:0], sda_s};
            end else begin
                nxt_smb_nack = sda_s;
            end
            nxt_smb_cnt = smb_cnt_ff + 4'h1;
        end else if (smb_st_ff != eqc_pkg::SMB_IDLE && !scl_s && prev_ff[1]) begin
            if (smb_cnt_ff == eqc_pkg::SMB_ACK_BIT) begin
                // acknowledge slot begins
                nxt_sda_oe = (smb_st_ff != eqc_pkg::SMB_READ);
                if (smb_st_ff == eqc_pkg::SMB_ADDR && smb_sh_ff[7:1] != saddr_ff) begin
                    nxt_smb_st = eqc_pkg::SMB_IDLE;
                    nxt_sda_oe = 1'b0;
                end
                if (smb_st_ff == eqc_pkg::SMB_REG) begin
                    nxt_smb_ptr = smb_sh_ff;
                end
                smb_wr = (smb_st_ff == eqc_pkg::SMB_DATA);
            end else if (smb_cnt_ff == eqc_pkg::SMB_END_BIT) begin
                nxt_smb_cnt = 4'h0;
                nxt_sda_oe = 1'b0;
                case (smb_st_ff)
                    eqc_pkg::SMB_ADDR: nxt_smb_st = smb_sh_ff[0] ? eqc_pkg::SMB_READ
                                                                   : eqc_pkg::SMB_REG;
                    eqc_pkg::SMB_REG: nxt_smb_st = eqc_pkg::SMB_DATA;
                    eqc_pkg::SMB_DATA: nxt_smb_st = eqc_pkg::SMB_DATA;
                    eqc_pkg::SMB_READ: nxt_smb_st = smb_nack_ff ? eqc_pkg::SMB_IDLE
                                                                : eqc_pkg::SMB_READ;
                    default: nxt_smb_st = eqc_pkg::SMB_IDLE;
                endcase
                if (nxt_smb_st == eqc_pkg::SMB_READ) begin
                    nxt_smb_sh = rd_data(smb_ptr_ff);
                    nxt_sda_oe = !nxt_smb_sh[7];
                end
            end else if (smb_st_ff == eqc_pkg::SMB_READ) begin
                nxt_sda_oe = !smb_sh_ff[7];
            end
        end
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            smb_st_ff <= eqc_pkg::SMB_IDLE;
            smb_cnt_ff <= 4'h0;
            smb_sh_ff <= 8'h00;
            smb_ptr_ff <= 8'h00;
            sda_oe_ff <= 1'b0;
            smb_nack_ff <= 1'b0;
        end else begin
            smb_st_ff <= nxt_smb_st;
            smb_cnt_ff <= nxt_smb_cnt;
            smb_sh_ff <= nxt_smb_sh;
            smb_ptr_ff <= nxt_smb_ptr;
            sda_oe_ff <= nxt_sda_oe;
            smb_nack_ff <= nxt_smb_nack;
        end
    end

    // register file, only one port is live for a given mode
    always_comb begin
        logic [7:0] wa, wd;
        wa = spi_wr ? spi_wa : smb_ptr_ff;
        wd = spi_wr ? spi_wd : smb_wd;
        nxt_mute = mute_ff;
        nxt_amp0 = amp0_ff;
        nxt_dem0 = dem0_ff;
        nxt_amp1 = amp1_ff;
        nxt_dem1 = dem1_ff;
        nxt_path = path_ff;
        if (spi_wr || smb_wr) begin
            case (wa)
                eqc_pkg::ADDR_MUTE: nxt_mute = wd & eqc_pkg::MASK_MUTE;
                eqc_pkg::ADDR_AMP0: nxt_amp0 = wd & eqc_pkg::MASK_AMP;
                eqc_pkg::ADDR_DEM0: nxt_dem0 = wd & eqc_pkg::MASK_DEM;
                eqc_pkg::ADDR_AMP1: nxt_amp1 = wd & eqc_pkg::MASK_AMP;
                eqc_pkg::ADDR_DEM1: nxt_dem1 = wd & eqc_pkg::MASK_DEM;
                eqc_pkg::ADDR_PATH: nxt_path = wd & eqc_pkg::MASK_PATH;
                default: nxt_path = path_ff; // read-only or unmapped
            endcase
        end
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mute_ff <= eqc_pkg::RST_MUTE;
            amp0_ff <= eqc_pkg::RST_DRV;
            dem0_ff <= eqc_pkg::RST_DRV;
            amp1_ff <= eqc_pkg::RST_DRV;
            dem1_ff <= eqc_pkg::RST_DRV;
            path_ff <= eqc_pkg::RST_PATH;
        end else begin
            mute_ff <= nxt_mute;
            amp0_ff <= nxt_amp0;
            dem0_ff <= nxt_dem0;
            amp1_ff <= nxt_amp1;
            dem1_ff <= nxt_dem1;
            path_ff <= nxt_path;
        end
    end

    // datapath control; reserved strap levels fall back to the single-output, eq path
    always_comb begin
        logic both;
        logic [2:0] code;
        code = eqc_pkg::lvl_code(drv_lvl);
        both = path_ff[eqc_pkg::PATH_ROUTE_OVR] ? path_ff[eqc_pkg::PATH_ROUTE_BOTH]
                                                : (route_lvl == eqc_pkg::LVL_H);
        nxt_output_zero = !psave;
        nxt_output_one = both && !psave;
        nxt_byp = path_ff[eqc_pkg::PATH_FUNC_OVR] ? path_ff[eqc_pkg::PATH_FUNC_BYP]
                                                  : (func_lvl == eqc_pkg::LVL_H);
        nxt_drv0.amp = amp0_ff[eqc_pkg::AMP_OVR_BIT] ? amp0_ff[2:0] : code;
        nxt_drv0.deemphasis_level = dem0_ff[eqc_pkg::DEM_OVR_BIT] ? dem0_ff[2:0] : code;
        nxt_drv1.amp = amp1_ff[eqc_pkg::AMP_OVR_BIT] ? amp1_ff[2:0] : code;
        nxt_drv1.deemphasis_level = dem1_ff[eqc_pkg::DEM_OVR_BIT] ? dem1_ff[2:0] : code;
        nxt_mute_o = cli_rd > mute_ff[5:0];
        nxt_cdn = !(car_s && adp_s) || psave;
        nxt_eqpd = !car_s || psave;
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            output_zero_ff <= 1'b0;
            output_one_ff <= 1'b0;
            byp_ff <= 1'b0;
            drv0_ff <= '0;
            drv1_ff <= '0;
            split_ff <= 1'b0;
            mute_o_ff <= 1'b1;
            cdn_ff <= 1'b1;
            eqpd_ff <= 1'b1;
            ps_ff <= 1'b0;
            smbm_ff <= 1'b0;
        end else begin
            output_zero_ff <= nxt_output_zero;
            output_one_ff <= nxt_output_one;
            byp_ff <= nxt_byp;
            drv0_ff <= nxt_drv0;
            drv1_ff <= nxt_drv1;
            split_ff <= path_ff[eqc_pkg::PATH_SPLIT];
            mute_o_ff <= nxt_mute_o;
            cdn_ff <= nxt_cdn;
            eqpd_ff <= nxt_eqpd;
            ps_ff <= psave;
            smbm_ff <= smb_en;
        end
    end

    assign spi_miso_o = miso_ff;
    assign spi_miso_oe_o = miso_oe_ff;
    assign smb_sda_o = 1'b0;
    assign smb_sda_oe_o = sda_oe_ff;
    assign output_zero_en_o = output_zero_ff;
    assign output_one_en_o = output_one_ff;
    assign eq_bypass_o = byp_ff;
    assign output_zero_drv_o = drv0_ff;
    assign output_one_drv_o = drv1_ff;
    assign splitter_mode_o = split_ff;
    assign mute_o = mute_o_ff;
    assign carrier_present_n_o = cdn_ff;
    assign eq_power_down_o = eqpd_ff;
    assign power_save_o = ps_ff;
    assign smbus_mode_o = smbm_ff;

    // checks on the control outputs
    property p_route_both;
        @(posedge clk_sys_i) disable iff (rst_i)
        !path_ff[0] && route_lvl == eqc_pkg::LVL_F |=> !output_one_en_o;
    endproperty
    a_route_both: assert property (p_route_both) else $error("output one not disabled");
    property p_route_ovr;
        @(posedge clk_sys_i) disable iff (rst_i)
        path_ff[0] && path_ff[1] && !psave |=> output_one_en_o && output_zero_en_o;
    endproperty
    a_route_ovr: assert property (p_route_ovr) else $error("route override ignored");
    property p_bypass;
        @(posedge clk_sys_i) disable iff (rst_i)
        !path_ff[2] && func_lvl == eqc_pkg::LVL_H |=> eq_bypass_o;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass strap not followed");
    property p_strap_l;
        @(posedge clk_sys_i) disable iff (rst_i)
        !amp0_ff[5] && drv_lvl == eqc_pkg::LVL_L |=> output_zero_drv_o.amp == 3'h5;
    endproperty
    a_strap_l: assert property (p_strap_l) else $error("strap code L not 5");
    property p_amp_ovr;
        @(posedge clk_sys_i) disable iff (rst_i)
        amp1_ff[5] |=> output_one_drv_o.amp == $past(amp1_ff[2:0]);
    endproperty
    a_amp_ovr: assert property (p_amp_ovr) else $error("amplitude override ignored");
    property p_dem_strap;
        @(posedge clk_sys_i) disable iff (rst_i)
        !dem0_ff[6] |=> output_zero_drv_o.deemphasis_level == eqc_pkg::lvl_code($past(drv_lvl));
    endproperty
    a_dem_strap: assert property (p_dem_strap) else $error("field used without override");
    property p_mute;
        @(posedge clk_sys_i) disable iff (rst_i)
        cli_rd > mute_ff[5:0] ##1 cli_rd > mute_ff[5:0] |-> mute_o;
    endproperty
    a_mute: assert property (p_mute) else $error("long cable not muted");
    property p_carrier;
        @(posedge clk_sys_i) disable iff (rst_i)
        !car_s |=> carrier_present_n_o && eq_power_down_o;
    endproperty
    a_carrier: assert property (p_carrier) else $error("carrier loss not flagged");
    property p_smb_off;
        @(posedge clk_sys_i) disable iff (rst_i)
        !smb_en |=> !smb_sda_oe_o;
    endproperty
    a_smb_off: assert property (p_smb_off) else $error("smbus drives outside its mode");
    property p_split;
        @(posedge clk_sys_i) disable iff (rst_i)
        $rose(path_ff[4]) |-> ##1 splitter_mode_o;
    endproperty
    a_split: assert property (p_split) else $error("splitter bit not applied");
endmodule // eqc_top

// [dv/eqc_spi_host.sv]
// spi host model for the register port of the equalizer block
module eqc_spi_host (
    // bench clock
    input wire logic clk_sys_i,
    // spi wires
    output logic spi_sck_o,
    output logic spi_mosi_o,
    output logic spi_ss_n_o,
    input wire logic spi_miso_i
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle: select high, clock parked low, it only runs inside frames
    initial begin
        spi_sck_o = 1'b0;
        spi_ss_n_o = 1'b1;
        spi_mosi_o = 1'b1;
    end
    // one 17-bit frame, msb first, sck 4 clocks high and 4 low
    task automatic xfer(input logic [16:0] f, output logic [16:0] r);
        @(negedge clk_sys_i);
        spi_ss_n_o = 1'b0;
        for (int i = 16; i >= 0; i--) begin
            spi_mosi_o = f[i];
            repeat (4) @(negedge clk_sys_i);
            r[i] = spi_miso_i;
            spi_sck_o = 1'b1;
            repeat (4) @(negedge clk_sys_i);
            spi_sck_o = 1'b0;
        end
        repeat (4) @(negedge clk_sys_i);
        spi_ss_n_o = 1'b1;
        spi_mosi_o = ~spi_mosi_o; // released line must not keep the last bit
        repeat (6) @(negedge clk_sys_i);
    endtask
endmodule // eqc_spi_host

// [dv/equalizer_config_control_tb_top.sv]
// self-checking bench for the equalizer configuration block
module equalizer_config_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [2:0] TH[4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    localparam logic [2:0] CODE[4] = '{3'h5, 3'h3, 3'h2, 3'h0};
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [2:0] rte = 3'h3, fnc = 3'h3, dls = 3'h3, mds = 3'h3;
    logic [5:0] cable_length_estimate = 6'h00;
    logic above = 1'b0, adapt = 1'b0;
    logic sck, mosi, ss_n, miso, en0, en1, byp, split, mute, cd_n, pd, psave, smb;
    logic scl = 1'b1, sda_m = 1'b1, moe, sda_oe, sda_o;
    // open-drain line with its pull-up
    wire sda_ln = sda_m && !(sda_oe && !sda_o);
    eqc_pkg::eqc_drv_t drv0, drv1;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [16:0] r;
    always #50 clk_sys_i = ~clk_sys_i;
    // address straps tied to L, so the smbus address is the base one
    eqc_top u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .route_strap_i(rte),
        .func_strap_i(fnc), .drive_level_strap_i(dls), .mode_strap_i(mds),
        .addr0_strap_i(3'h0), .addr1_strap_i(3'h0), .cable_length_indicator_i(cable_length_estimate),
        .carrier_above_i(above), .adapt_done_i(adapt), .spi_sck_i(sck), .spi_mosi_i(mosi),
        .spi_ss_n_i(ss_n), .spi_miso_o(miso), .spi_miso_oe_o(moe), .smb_scl_i(scl),
        .smb_sda_i(sda_ln), .smb_sda_o(sda_o), .smb_sda_oe_o(sda_oe), .output_zero_en_o(en0),
        .output_one_en_o(en1), .eq_bypass_o(byp), .output_zero_drv_o(drv0),
        .output_one_drv_o(drv1), .splitter_mode_o(split), .mute_o(mute),
        .carrier_present_n_o(cd_n), .eq_power_down_o(pd), .power_save_o(psave),
        .smbus_mode_o(smb));
    eqc_spi_host u_host (.clk_sys_i(clk_sys_i), .spi_sck_o(sck), .spi_mosi_o(mosi),
        .spi_ss_n_o(ss_n), .spi_miso_i(moe ? miso : 1'b1));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one smbus phase: set clock and data, hold 5 clocks
    task automatic sdrv(input logic c, input logic d);
        scl = c;
        sda_m = d;
        repeat (5) @(negedge clk_sys_i);
    endtask
    // nine bits msb first, the last is the ack slot
    task automatic sbyte(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            sdrv(1'b0, d[i]);
            sdrv(1'b1, d[i]);
            q[i] = sda_ln;
        end
    endtask
    // start, or stop when p is set
    task automatic scond(input logic p);
        sdrv(1'b0, !p);
        sdrv(1'b1, !p);
        sdrv(1'b1, p);
    endtask
    // write, then let the register and output flops land
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.xfer({1'b0, a, d}, r);
        repeat (8) @(negedge clk_sys_i);
    endtask
    // read needs a second dummy frame to shift the answer out
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        u_host.xfer({1'b1, a, 8'hFF}, r);
        u_host.xfer(17'h1FFFF, r);
        chk(r[15:8], a);
        chk(r[7:0], exp);
    endtask
    task automatic t_regs;
        cable_length_estimate = 6'h3F;
        rd(8'h03, 8'h3F);
        wr(8'h25, 8'h11);
        rd(8'h25, 8'h37);
        wr(8'h7E, 8'hAA);
        rd(8'h7E, 8'h00);
        wr(8'h30, 8'hFF);
        rd(8'h30, 8'h27);
        wr(8'h30, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_straps;
        for (int l = 0; l < 4; l++) begin
            rte = TH[l];
            fnc = TH[l];
            dls = TH[l];
            repeat (6) @(negedge clk_sys_i);
            chk({2'h0, drv0}, {2'h0, CODE[l], CODE[l]});
            chk({2'h0, drv1}, {2'h0, CODE[l], CODE[l]});
            chk({5'h0, en0, en1, byp}, {5'h0, 1'b1, l == 3, l == 3});
        end
        $display("test straps done");
    endtask
    task automatic t_ovr;
        rte = TH[2];
        fnc = TH[2];
        dls = TH[2];
        wr(8'h30, 8'h27);
        chk({2'h0, drv0}, 8'h3A);
        chk({2'h0, drv1}, 8'h12);
        wr(8'h31, 8'h04);
        chk({2'h0, drv0}, 8'h3A);
        wr(8'h33, 8'h41);
        chk({2'h0, drv1}, 8'h11);
        wr(8'h32, 8'h26);
        chk({2'h0, drv1}, 8'h31);
        wr(8'h10, 8'h1F);
        chk({5'h0, en1, byp, split}, 8'h07);
        wr(8'h10, 8'h00);
        chk({5'h0, en1, byp, split}, 8'h00);
        $display("test override done");
    endtask
    task automatic t_mute;
        cable_length_estimate = 6'h14;
        rd(8'h25, 8'h14);
        wr(8'h03, 8'h14);
        chk({7'h0, mute}, 8'h00);
        cable_length_estimate = 6'h15;
        repeat (6) @(negedge clk_sys_i);
        chk({7'h0, mute}, 8'h01);
        $display("test mute done");
    endtask
    task automatic t_carrier;
        above = 1'b1;
        repeat (6) @(negedge clk_sys_i);
        chk({6'h0, cd_n, pd}, 8'h02);
        adapt = 1'b1;
        repeat (6) @(negedge clk_sys_i);
        chk({7'h0, cd_n}, 8'h00);
        above = 1'b0;
        repeat (6) @(negedge clk_sys_i);
        chk({6'h0, cd_n, pd}, 8'h03);
        $display("test carrier done");
    endtask
    // mode strap moves only under reset, never straight between L and H
    task automatic t_mode;
        for (int l = 3; l >= 0; l--) begin
            if (l == 1) continue;
            rst_i = 1'b1;
            mds = TH[l];
            repeat (4) @(negedge clk_sys_i);
            rst_i = 1'b0;
            repeat (10) @(negedge clk_sys_i);
            chk({6'h0, smb, psave}, {6'h0, l == 0, l == 3});
        end
        $display("test mode done");
    endtask
    // write, then a repeated start reads the same register back
    task automatic t_smb;
        logic [8:0] q;
        scond(1'b0);
        sbyte({8'h3A, 1'b1}, q);
        chk({7'h0, q[0]}, 8'h00);
        sbyte({8'h03, 1'b1}, q);
        sbyte({8'h2A, 1'b1}, q);
        scond(1'b0);
        sbyte({8'h3B, 1'b1}, q);
        sbyte(9'h1FF, q);
        scond(1'b1);
        chk(q[8:1], 8'h2A);
        $display("test smbus done");
    endtask
    task automatic finish_test;
        $display("counts: mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // watchdog well beyond the roughly 3800 cycles the tests need
    initial begin
        repeat (30000) @(posedge clk_sys_i);
        n_mismatch++;
        finish_test();
    end
    initial begin
        repeat (12) @(negedge clk_sys_i);
        rst_i = 1'b0;
        repeat (8) @(negedge clk_sys_i);
        t_regs();
        t_straps();
        t_ovr();
        t_mute();
        t_carrier();
        t_mode();
        t_smb();
        finish_test();
    end
endmodule // equalizer_config_control_tb_top
